// ===== hw/csfl_pkg.sv
// Purpose: shared constants and types for the shift, flag, load and store unit
// Assumes: 8-bit data, 16-bit data addresses, one core clock
// Notes: register offsets are byte addresses of 32-bit APB words
package csfl_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] CSFL_OFF_CMD = 8'h00;
   localparam logic [7:0] CSFL_OFF_OPND = 8'h04;
   localparam logic [7:0] CSFL_OFF_FLAGS = 8'h08;
   localparam logic [7:0] CSFL_OFF_STATUS = 8'h0c;
   localparam logic [7:0] CSFL_OFF_GPR_BASE = 8'h80;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CSFL_CMD_OP_LSB = 0;
   localparam int CSFL_CMD_RD_LSB = 8;
   localparam int CSFL_CMD_PTR_LSB = 16;
   localparam int CSFL_CMD_BIT_LSB = 20;
   localparam int CSFL_OPND_Q_LSB = 0;
   localparam int CSFL_OPND_K_LSB = 8;
   localparam int CSFL_FLG_C = 0;
   localparam int CSFL_FLG_Z = 1;
   localparam int CSFL_FLG_N = 2;
   localparam int CSFL_FLG_V = 3;
   localparam int CSFL_FLG_S = 4;
   localparam int CSFL_FLG_H = 5;
   localparam int CSFL_FLG_T = 6;
   localparam int CSFL_FLG_I = 7;
   // ------------------------------------------------------------
   // Reset values and timing
   // ------------------------------------------------------------
   localparam logic [7:0] CSFL_FLAGS_RST = 8'h00;
   localparam logic [7:0] CSFL_GPR_RST = 8'h00;
   localparam int CSFL_MEM_CYCLES = 2;
   // Pointer pairs: X at 26/27, Y at 28/29, Z at 30/31
   localparam logic [4:0] CSFL_PTR_X_LO = 5'h1a;
   localparam logic [4:0] CSFL_PTR_Y_LO = 5'h1c;
   localparam logic [4:0] CSFL_PTR_Z_LO = 5'h1e;

   typedef enum logic [4:0] {
      CSFL_OP_NOP = 5'h00,
      CSFL_OP_ROTATE_RIGHT_CARRY = 5'h01,
      CSFL_OP_ARITH_SHIFT_RIGHT = 5'h02,
      CSFL_OP_LOGIC_SHIFT_RIGHT = 5'h03,
      CSFL_OP_FLAG_STORE_BIT = 5'h04,
      CSFL_OP_FLAG_LOAD_BIT = 5'h05,
      CSFL_OP_HALF_FLAG_SET = 5'h06,
      CSFL_OP_HALF_FLAG_CLEAR = 5'h07,
      CSFL_OP_OVF_FLAG_SET = 5'h08,
      CSFL_OP_OVF_FLAG_CLEAR = 5'h09,
      CSFL_OP_SIGN_FLAG_SET = 5'h0a,
      CSFL_OP_SIGN_FLAG_CLEAR = 5'h0b,
      CSFL_OP_INDIRECT_LOAD = 5'h0c,
      CSFL_OP_LOAD_POST_INC = 5'h0d,
      CSFL_OP_LOAD_PRE_DEC = 5'h0e,
      CSFL_OP_DISPLACED_LOAD = 5'h0f,
      CSFL_OP_DIRECT_LOAD = 5'h10,
      CSFL_OP_PTR_WRITE = 5'h11,
      CSFL_OP_WRITE_POST_INC = 5'h12,
      CSFL_OP_WRITE_PRE_DEC = 5'h13
   } csfl_op_e;

   typedef enum logic [1:0] {
      CSFL_PTR_X = 2'h0,
      CSFL_PTR_Y = 2'h1,
      CSFL_PTR_Z = 2'h2
   } csfl_ptr_e;
endpackage : csfl_pkg

// ===== hw/csfl_shift_if.sv
// Purpose: carries shift requests between the unit and its shifter
// Assumes: combinational shifter
// Notes: none
interface csfl_shift_if;
   import csfl_pkg::*;
   csfl_op_e op;
   logic [7:0] din;
   logic carry_in;
   logic [7:0] dout;
   logic [7:0] flags_out;
   logic [7:0] flags_in;
   modport unit (output op, output din, output carry_in, output flags_in, input dout,
                 input flags_out);
   modport shifter (input op, input din, input carry_in, input flags_in, output dout,
                    output flags_out);
endinterface : csfl_shift_if

// ===== hw/csfl_shifter.sv
// Purpose: right shifts through carry and their flag results
// Assumes: flags_in is the current flag register
// Notes: S is refreshed as N xor V, as a full core would
module csfl_shifter
   import csfl_pkg::*;
(
   csfl_shift_if.shifter sh
);
   logic [7:0] res;
   logic cout;

   always_comb
   begin
      res = {1'b0, sh.din[7:1]};
      cout = sh.din[0];
      case (sh.op)
         CSFL_OP_ROTATE_RIGHT_CARRY: res = {sh.carry_in, sh.din[7:1]};
         CSFL_OP_ARITH_SHIFT_RIGHT: res = {sh.din[7], sh.din[7:1]};
         default: res = {1'b0, sh.din[7:1]};
      endcase
   end

   always_comb
   begin
      sh.dout = res;
      sh.flags_out = sh.flags_in;
      sh.flags_out[CSFL_FLG_C] = cout;
      sh.flags_out[CSFL_FLG_Z] = (res == 8'h00);
      sh.flags_out[CSFL_FLG_N] = res[7];
      sh.flags_out[CSFL_FLG_V] = res[7] ^ cout;
      sh.flags_out[CSFL_FLG_S] = cout;
   end
endmodule : csfl_shifter

// ===== hw/csfl_unit.sv
// Purpose: executes shift, flag-bit and data-memory load/store operations
// Assumes: software issues one operation at a time over APB
// Notes: data memory is an internal array; general registers are APB visible
//
// What this block does
// - Rotate right through carry: carry to bit 7, bit 0 to carry, sets Z C N V S, one cycle.
// - Arithmetic right shift keeps bit 7, shifts the rest down, sets Z C N V S, one cycle.
// - Bit store copies a chosen source bit into T, touching only T, one cycle.
// - Bit load writes T into a chosen destination bit, flags unchanged, one cycle.
// - Half-carry set and clear force H only, one cycle.
// - Overflow set and clear force V only, one cycle.
// - Sign set and clear force S only, one cycle.
// - Post-increment load reads at the pointer, then bumps it, flags kept, two cycles.
// - Pre-decrement load lowers the pointer first, then reads there, two cycles.
// - Displaced load reads at pointer plus displacement, pointer kept, two cycles.
// - Direct load reads the constant address, flags kept, two cycles.
// - Post-increment store writes at the pointer, then bumps it, two cycles.
// - Pre-decrement store lowers the pointer first, then writes there, two cycles.
// - Plain indirect load reads at the pointer and leaves it unchanged, two cycles.
// - Logical right shift clears bit 7, sets Z C N V S, one cycle.
//
// Implementation choices: the register addresses and the APB slave port.
module csfl_unit
   import csfl_pkg::*;
#(
   parameter int MEM_DEPTH = 256
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic busy,
   output logic [7:0] flag_register
);
   import csfl_pkg::*;

   localparam int AW = $clog2(MEM_DEPTH);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum logic [0:0] {CSFL_IDLE, CSFL_MEM} csfl_state_e;

   csfl_state_e state_q;
   logic [7:0] gpr_q [32];
   logic [7:0] mem_q [MEM_DEPTH];
   logic [7:0] flags_q;
   logic [4:0] op_q;
   logic [4:0] rd_q;
   logic [1:0] ptr_sel_q;
   logic [2:0] bit_q;
   logic [5:0] q_q;
   logic [15:0] k_q;
   logic [15:0] addr_q;
   logic [31:0] cmd_q;
   logic [31:0] opnd_q;
   logic [7:0] done_cnt_q;

   logic wr_en;
   logic rd_en;
   logic start;
   logic [4:0] ptr_lo;
   logic [15:0] ptr_val;
   logic [15:0] ptr_inc;
   logic [15:0] ptr_dec;
   logic [15:0] eff_addr;
   logic ptr_upd;
   logic [15:0] ptr_new;
   logic gpr_wr;
   logic [4:0] gpr_wr_idx;
   logic [7:0] gpr_wr_dat;
   csfl_op_e op_now;

   csfl_shift_if sh ();

   csfl_shifter u_shifter (
      .sh(sh)
   );

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign op_now = csfl_op_e'(pwdata[CSFL_CMD_OP_LSB +: 5]);
   assign start = wr_en && (paddr == CSFL_OFF_CMD) && (state_q == CSFL_IDLE);

   // ------------------------------------------------------------
   // Address generation
   // ------------------------------------------------------------
   always_comb
   begin
      if (pwdata[CSFL_CMD_PTR_LSB +: 2] == CSFL_PTR_X)
      begin
         ptr_lo = CSFL_PTR_X_LO;
      end
      else if (pwdata[CSFL_CMD_PTR_LSB +: 2] == CSFL_PTR_Y)
      begin
         ptr_lo = CSFL_PTR_Y_LO;
      end
      else
      begin
         ptr_lo = CSFL_PTR_Z_LO;
      end
   end

   assign ptr_val = {gpr_q[ptr_lo + 5'd1], gpr_q[ptr_lo]};
   assign ptr_inc = ptr_val + 16'h0001;
   assign ptr_dec = ptr_val - 16'h0001;

   always_comb
   begin
      eff_addr = ptr_val;
      ptr_upd = 1'b0;
      ptr_new = ptr_val;
      case (op_now)
         CSFL_OP_LOAD_POST_INC, CSFL_OP_WRITE_POST_INC:
         begin
            ptr_upd = 1'b1;
            ptr_new = ptr_inc;
         end
         CSFL_OP_LOAD_PRE_DEC, CSFL_OP_WRITE_PRE_DEC:
         begin
            eff_addr = ptr_dec;
            ptr_upd = 1'b1;
            ptr_new = ptr_dec;
         end
         CSFL_OP_DISPLACED_LOAD:
            eff_addr = ptr_val + {10'h000, opnd_q[CSFL_OPND_Q_LSB +: 6]};
         CSFL_OP_DIRECT_LOAD:
            eff_addr = opnd_q[CSFL_OPND_K_LSB +: 16];
         default:
            eff_addr = ptr_val;
      endcase
   end

   assign sh.op = op_now;
   assign sh.din = gpr_q[pwdata[CSFL_CMD_RD_LSB +: 5]];
   assign sh.carry_in = flags_q[CSFL_FLG_C];
   assign sh.flags_in = flags_q;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   // Memory ops hold busy for the second cycle; a new command is refused meanwhile
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         state_q <= CSFL_IDLE;
         op_q <= 5'h00;
         rd_q <= 5'h00;
         addr_q <= 16'h0000;
         ptr_sel_q <= 2'h0;
         bit_q <= 3'h0;
         q_q <= 6'h00;
         k_q <= 16'h0000;
      end
      else
      begin
         case (state_q)
            CSFL_IDLE:
               if (start && (op_now >= CSFL_OP_INDIRECT_LOAD)
                   && (op_now <= CSFL_OP_WRITE_PRE_DEC))
               begin
                  state_q <= CSFL_MEM;
                  op_q <= op_now;
                  rd_q <= pwdata[CSFL_CMD_RD_LSB +: 5];
                  addr_q <= eff_addr;
                  ptr_sel_q <= pwdata[CSFL_CMD_PTR_LSB +: 2];
                  bit_q <= pwdata[CSFL_CMD_BIT_LSB +: 3];
                  q_q <= opnd_q[CSFL_OPND_Q_LSB +: 6];
                  k_q <= opnd_q[CSFL_OPND_K_LSB +: 16];
               end
            default:
               state_q <= CSFL_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         busy <= 1'b0;
      end
      else
      begin
         busy <= start && (op_now >= CSFL_OP_INDIRECT_LOAD)
                 && (op_now <= CSFL_OP_WRITE_PRE_DEC);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         done_cnt_q <= 8'h00;
      end
      else if (start || (state_q == CSFL_MEM))
      begin
         done_cnt_q <= done_cnt_q + 8'h01;
      end
   end

   // ------------------------------------------------------------
   // Register file write port
   // ------------------------------------------------------------
   always_comb
   begin
      gpr_wr = 1'b0;
      gpr_wr_idx = pwdata[CSFL_CMD_RD_LSB +: 5];
      gpr_wr_dat = 8'h00;
      if (state_q == CSFL_MEM)
      begin
         gpr_wr_idx = rd_q;
         gpr_wr_dat = mem_q[addr_q[AW-1:0]];
         gpr_wr = (op_q <= CSFL_OP_DIRECT_LOAD);
      end
      else if (start)
      begin
         if ((op_now == CSFL_OP_ROTATE_RIGHT_CARRY) || (op_now == CSFL_OP_ARITH_SHIFT_RIGHT)
             || (op_now == CSFL_OP_LOGIC_SHIFT_RIGHT))
         begin
            gpr_wr = 1'b1;
            gpr_wr_dat = sh.dout;
         end
         else if (op_now == CSFL_OP_FLAG_LOAD_BIT)
         begin
            gpr_wr = 1'b1;
            gpr_wr_dat = sh.din;
            gpr_wr_dat[pwdata[CSFL_CMD_BIT_LSB +: 3]] = flags_q[CSFL_FLG_T];
         end
      end
      else if (wr_en && (paddr >= CSFL_OFF_GPR_BASE))
      begin
         gpr_wr = 1'b1;
         gpr_wr_idx = paddr[6:2];
         gpr_wr_dat = pwdata[7:0];
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < 32; i++)
         begin
            gpr_q[i] <= CSFL_GPR_RST;
         end
      end
      else
      begin
         if (gpr_wr)
         begin
            gpr_q[gpr_wr_idx] <= gpr_wr_dat;
         end
         // Pointer update in the first cycle; a load into the pointer register writes one cycle later and wins
         if (start && ptr_upd)
         begin
            gpr_q[ptr_lo] <= ptr_new[7:0];
            gpr_q[ptr_lo + 5'd1] <= ptr_new[15:8];
         end
      end
   end

   // ------------------------------------------------------------
   // Data memory
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if ((state_q == CSFL_MEM) && (op_q >= CSFL_OP_PTR_WRITE))
      begin
         mem_q[addr_q[AW-1:0]] <= gpr_q[rd_q];
      end
   end

   // ------------------------------------------------------------
   // Flags
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         flags_q <= CSFL_FLAGS_RST;
      end
      else if (start)
      begin
         case (op_now)
            CSFL_OP_ROTATE_RIGHT_CARRY, CSFL_OP_ARITH_SHIFT_RIGHT, CSFL_OP_LOGIC_SHIFT_RIGHT:
               flags_q <= sh.flags_out;
            CSFL_OP_FLAG_STORE_BIT:
               flags_q[CSFL_FLG_T] <= sh.din[pwdata[CSFL_CMD_BIT_LSB +: 3]];
            CSFL_OP_HALF_FLAG_SET:
               flags_q[CSFL_FLG_H] <= 1'b1;
            CSFL_OP_HALF_FLAG_CLEAR:
               flags_q[CSFL_FLG_H] <= 1'b0;
            CSFL_OP_OVF_FLAG_SET:
               flags_q[CSFL_FLG_V] <= 1'b1;
            CSFL_OP_OVF_FLAG_CLEAR:
               flags_q[CSFL_FLG_V] <= 1'b0;
            CSFL_OP_SIGN_FLAG_SET:
               flags_q[CSFL_FLG_S] <= 1'b1;
            CSFL_OP_SIGN_FLAG_CLEAR:
               flags_q[CSFL_FLG_S] <= 1'b0;
            default:
               flags_q <= flags_q;
         endcase
      end
      else if (wr_en && (paddr == CSFL_OFF_FLAGS))
      begin
         flags_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         flag_register <= CSFL_FLAGS_RST;
      end
      else
      begin
         flag_register <= flags_q;
      end
   end

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         cmd_q <= 32'h0000_0000;
         opnd_q <= 32'h0000_0000;
      end
      else if (wr_en && (paddr == CSFL_OFF_CMD))
      begin
         cmd_q <= pwdata;
      end
      else if (wr_en && (paddr == CSFL_OFF_OPND))
      begin
         opnd_q <= pwdata;
      end
   end

   // Zero-wait answer; pready is a registered copy of the setup phase
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && (paddr[1:0] != 2'b00
                    || (pwrite && paddr == CSFL_OFF_CMD && state_q != CSFL_IDLE));
         prdata <= 32'h0000_0000;
         if (psel && !penable && !pwrite)
         begin
            if (paddr == CSFL_OFF_CMD)
            begin
               prdata <= cmd_q;
            end
            else if (paddr == CSFL_OFF_OPND)
            begin
               prdata <= opnd_q;
            end
            else if (paddr == CSFL_OFF_FLAGS)
            begin
               prdata <= {24'h000000, flags_q};
            end
            else if (paddr == CSFL_OFF_STATUS)
            begin
               prdata <= {16'h0000, done_cnt_q, 7'h00, (state_q != CSFL_IDLE)};
            end
            else if (paddr >= CSFL_OFF_GPR_BASE)
            begin
               prdata <= {24'h000000, gpr_q[paddr[6:2]]};
            end
         end
      end
   end

   logic unused_ok;
   assign unused_ok = rd_en ^ (^ptr_sel_q) ^ (^bit_q) ^ (^q_q) ^ (^k_q);
endmodule : csfl_unit

// ===== tb/csfl_unit_properties.sv
// Purpose: port-level checks of the shift, flag and memory unit
// Assumes: APB answer comes one cycle after setup
// Notes: bound to every csfl_unit instance
module csfl_unit_properties #(
   parameter int MEM_DEPTH = 256
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic busy,
   input wire logic [7:0] flag_register
);
   timeunit 1ns;
   timeprecision 1ps;
   import csfl_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ----
   // Decode
   // ----
   logic acc, cmd_wr, mem_cmd, reg_cmd;
   assign acc = psel && penable && pready;
   assign cmd_wr = acc && pwrite && paddr == CSFL_OFF_CMD && !pslverr;
   assign mem_cmd = cmd_wr && pwdata[4:0] >= 5'h0c && pwdata[4:0] <= 5'h13;
   assign reg_cmd = cmd_wr && pwdata[4:0] >= 5'h01 && pwdata[4:0] <= 5'h0b;
   sequence s_two_cycles;
      busy ##1 !busy;
   endsequence
   sequence s_flags_hold;
      ##1 $stable(flag_register) [*2];
   endsequence
   a_ready_access: assert property (psel && !penable |=> pready)
      else $error("no ready in access cycle");
   a_ready_only: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   a_err_misalign: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("misaligned access not refused");
   a_err_clean: assert property (acc && paddr[1:0] == 2'h0 && !busy |-> !pslverr)
      else $error("aligned access refused");
   a_mem_two: assert property (mem_cmd |=> s_two_cycles)
      else $error("memory op not two cycles");
   a_reg_one: assert property (reg_cmd |=> !busy)
      else $error("register op not one cycle");
   a_mem_flags: assert property (mem_cmd |=> s_flags_hold)
      else $error("memory op changed flags");
   a_bitld_flags: assert property (
      cmd_wr && pwdata[4:0] == CSFL_OP_FLAG_LOAD_BIT |=> ##1 $stable(flag_register))
      else $error("bit load changed flags");
   a_flags_copy: assert property (
      acc && pwrite && paddr == CSFL_OFF_FLAGS |-> ##2 flag_register == $past(pwdata[7:0], 2))
      else $error("flag output does not follow write");
endmodule : csfl_unit_properties

bind csfl_unit csfl_unit_properties #(.MEM_DEPTH(MEM_DEPTH)) props_i (.clk_sys(clk_sys),
   .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy),
   .flag_register(flag_register));

// ===== tb/csfl_far_model.sv
// Purpose: far-side model: register file, flag register and data memory
// Assumes: one operation at a time, applied when its command is taken
// Notes: a load into its own pointer register keeps the loaded byte
module csfl_far_model;
   timeunit 1ns;
   timeprecision 1ps;
   import csfl_pkg::*;
   logic [7:0] gpr [32];
   logic [7:0] mem [256];
   logic [7:0] flg;
   task automatic run(input csfl_op_e op, input logic [4:0] r, input logic [1:0] ps,
                      input logic [2:0] b, input logic [5:0] q, input logic [15:0] k);
      logic [4:0] lo;
      logic [15:0] p, a;
      logic [7:0] v;
      logic ld, st;
      lo = (ps == 2'h0) ? CSFL_PTR_X_LO : (ps == 2'h1) ? CSFL_PTR_Y_LO : CSFL_PTR_Z_LO;
      p = {gpr[lo + 5'h01], gpr[lo]};
      a = p;
      v = gpr[r];
      ld = op inside {[CSFL_OP_INDIRECT_LOAD:CSFL_OP_DIRECT_LOAD]};
      st = op inside {[CSFL_OP_PTR_WRITE:CSFL_OP_WRITE_PRE_DEC]};
      case (op)
         CSFL_OP_ROTATE_RIGHT_CARRY, CSFL_OP_ARITH_SHIFT_RIGHT, CSFL_OP_LOGIC_SHIFT_RIGHT:
         begin
            v = {(op == CSFL_OP_ROTATE_RIGHT_CARRY) ? flg[CSFL_FLG_C] :
                 (op == CSFL_OP_ARITH_SHIFT_RIGHT) & v[7], v[7:1]};
            flg[CSFL_FLG_C] = gpr[r][0];
            flg[CSFL_FLG_Z] = (v == 8'h00);
            flg[CSFL_FLG_N] = v[7];
            flg[CSFL_FLG_V] = v[7] ^ gpr[r][0];
            // N xor V reduces to the new carry
            flg[CSFL_FLG_S] = gpr[r][0];
            gpr[r] = v;
         end
         CSFL_OP_FLAG_STORE_BIT: flg[CSFL_FLG_T] = v[b];
         CSFL_OP_FLAG_LOAD_BIT: gpr[r][b] = flg[CSFL_FLG_T];
         CSFL_OP_HALF_FLAG_SET, CSFL_OP_HALF_FLAG_CLEAR:
            flg[CSFL_FLG_H] = (op == CSFL_OP_HALF_FLAG_SET);
         CSFL_OP_OVF_FLAG_SET, CSFL_OP_OVF_FLAG_CLEAR:
            flg[CSFL_FLG_V] = (op == CSFL_OP_OVF_FLAG_SET);
         CSFL_OP_SIGN_FLAG_SET, CSFL_OP_SIGN_FLAG_CLEAR:
            flg[CSFL_FLG_S] = (op == CSFL_OP_SIGN_FLAG_SET);
         CSFL_OP_LOAD_POST_INC, CSFL_OP_WRITE_POST_INC: p = p + 16'h0001;
         CSFL_OP_LOAD_PRE_DEC, CSFL_OP_WRITE_PRE_DEC:
         begin
            p = p - 16'h0001;
            a = p;
         end
         CSFL_OP_DISPLACED_LOAD: a = p + {10'h000, q};
         CSFL_OP_DIRECT_LOAD: a = k;
         default: ;
      endcase
      if (ld || st)
      begin
         gpr[lo] = p[7:0];
         gpr[lo + 5'h01] = p[15:8];
      end
      if (st)
         mem[a[7:0]] = v;
      if (ld)
         gpr[r] = mem[a[7:0]];
   endtask : run
endmodule : csfl_far_model

// ===== tb/tb_csfl_unit.sv
// Purpose: self-checking bench of the shift, flag and memory unit
// Assumes: APB slave answers one cycle after setup
// Notes: expected values come from the far-side model
`define CHK(g, e) \
   begin \
      n_checks++; \
      if ((g) !== (e)) \
      begin \
         miscompares++; \
         $display("[ERR] %0t got %h exp %h", $time, g, e); \
      end \
   end
module tb_csfl_unit;
   timeunit 1ns;
   timeprecision 1ps;
   import csfl_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, busy, last_err;
   logic [7:0] flag_register;
   int miscompares = 0;
   int n_checks = 0;
   always #5 clk_sys = ~clk_sys;
   csfl_unit #(.MEM_DEPTH(256)) csfl_unit_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .busy(busy), .flag_register(flag_register));
   csfl_far_model far_i ();
   // ----
   // Tasks
   // ----
   task automatic tally_and_finish();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (n >= 16)
      begin
         miscompares++;
         tally_and_finish();
      end
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic [7:0] ga(input logic [4:0] r);
      return CSFL_OFF_GPR_BASE + {1'b0, r, 2'b00};
   endfunction : ga
   task automatic setg(input logic [4:0] r, input logic [7:0] v);
      logic [31:0] x;
      apb(1'b1, ga(r), {24'h0, v}, x);
      far_i.gpr[r] = v;
   endtask : setg
   task automatic setf(input logic [7:0] v);
      logic [31:0] x;
      apb(1'b1, CSFL_OFF_FLAGS, {24'h0, v}, x);
      far_i.flg = v;
   endtask : setf
   task automatic op(input csfl_op_e o, input logic [4:0] r, input logic [1:0] ps,
                     input logic [2:0] b, input logic [5:0] q, input logic [15:0] k);
      logic [31:0] v;
      logic [4:0] lo;
      lo = (ps == 2'h0) ? CSFL_PTR_X_LO : (ps == 2'h1) ? CSFL_PTR_Y_LO : CSFL_PTR_Z_LO;
      apb(1'b1, CSFL_OFF_OPND, {8'h00, k, 2'b00, q}, v);
      apb(1'b1, CSFL_OFF_CMD, {9'h000, b, 2'b00, ps, 3'b000, r, 3'b000, o}, v);
      far_i.run(o, r, ps, b, q, k);
      apb(1'b0, ga(r), 32'h0, v);
      `CHK(v, {24'h0, far_i.gpr[r]})
      apb(1'b0, CSFL_OFF_FLAGS, 32'h0, v);
      `CHK(v[7:0], far_i.flg)
      // Flag output pin must agree with the register once settled
      `CHK(flag_register, far_i.flg)
      `CHK(busy, 1'b0)
      apb(1'b0, ga(lo), 32'h0, v);
      `CHK(v[7:0], far_i.gpr[lo])
      apb(1'b0, ga(lo + 5'h01), 32'h0, v);
      `CHK(v[7:0], far_i.gpr[lo + 5'h01])
   endtask : op
   // ----
   // Sequence
   // ----
   initial
   begin
      repeat (100000) @(posedge clk_sys);
      miscompares++;
      tally_and_finish();
   end
   initial
   begin
      int i;
      int j;
      logic [31:0] v;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (i = 0; i < 32; i++)
      begin
         far_i.gpr[i] = CSFL_GPR_RST;
         apb(1'b0, ga(5'(i)), 32'h0, v);
         `CHK(v[7:0], CSFL_GPR_RST)
      end
      apb(1'b0, CSFL_OFF_FLAGS, 32'h0, v);
      `CHK(v[7:0], CSFL_FLAGS_RST)
      $display("test reset done");
      for (i = 0; i < 3; i++)
         for (j = 0; j < 2; j++)
         begin
            setg(5'h01, j ? 8'h81 : 8'h01);
            setf(j ? 8'he1 : 8'h1e);
            op(csfl_op_e'(5'(i + 1)), 5'h01, 2'h0, 3'h0, 6'h00, 16'h0);
         end
      $display("test shifts done");
      for (i = 6; i < 12; i++)
      begin
         setf(i[0] ? 8'hff : 8'h00);
         op(csfl_op_e'(5'(i)), 5'h00, 2'h0, 3'h0, 6'h00, 16'h0);
      end
      setg(5'h02, 8'h5a);
      setf(8'hbf);
      for (i = 0; i < 8; i++)
      begin
         setg(5'h03, 8'ha5);
         op(CSFL_OP_FLAG_STORE_BIT, 5'h02, 2'h0, 3'(i), 6'h00, 16'h0);
         op(CSFL_OP_FLAG_LOAD_BIT, 5'h03, 2'h0, 3'(i), 6'h00, 16'h0);
      end
      $display("test flags done");
      setf(8'h5a);
      setg(5'h1a, 8'h10);
      setg(5'h1b, 8'h00);
      setg(5'h04, 8'h11);
      op(CSFL_OP_WRITE_POST_INC, 5'h04, 2'h0, 3'h0, 6'h00, 16'h0);
      setg(5'h04, 8'h22);
      op(CSFL_OP_PTR_WRITE, 5'h04, 2'h0, 3'h0, 6'h00, 16'h0);
      setg(5'h04, 8'h33);
      op(CSFL_OP_WRITE_PRE_DEC, 5'h04, 2'h0, 3'h0, 6'h00, 16'h0);
      op(CSFL_OP_LOAD_POST_INC, 5'h05, 2'h0, 3'h0, 6'h00, 16'h0);
      op(CSFL_OP_INDIRECT_LOAD, 5'h07, 2'h0, 3'h0, 6'h00, 16'h0);
      op(CSFL_OP_LOAD_PRE_DEC, 5'h06, 2'h0, 3'h0, 6'h00, 16'h0);
      setg(5'h1c, 8'hd2);
      setg(5'h1d, 8'h00);
      op(CSFL_OP_DISPLACED_LOAD, 5'h08, 2'h1, 3'h0, 6'h3f, 16'h0);
      op(CSFL_OP_DIRECT_LOAD, 5'h09, 2'h0, 3'h0, 6'h00, 16'h0010);
      setg(5'h1e, 8'hff);
      setg(5'h1f, 8'hff);
      setg(5'h04, 8'h44);
      op(CSFL_OP_WRITE_POST_INC, 5'h04, 2'h2, 3'h0, 6'h00, 16'h0);
      op(CSFL_OP_LOAD_PRE_DEC, 5'h0a, 2'h2, 3'h0, 6'h00, 16'h0);
      $display("test memory done");
      apb(1'b1, 8'h05, 32'h0, v);
      `CHK(last_err, 1'b1)
      apb(1'b0, 8'h40, 32'h0, v);
      `CHK(v, 32'h0)
      `CHK(last_err, 1'b0)
      $display("test access errors done");
      tally_and_finish();
   end
endmodule : tb_csfl_unit
